// [pkg/dsp_pkg.sv]
// Constants shared by the debug status pin interface.
package dsp_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] PIN_ASSIGN_OFS = 8'h00;
  localparam logic [7:0] GP_DIR_OFS = 8'h04;
  localparam logic [7:0] GP_OUT_OFS = 8'h08;
  localparam logic [7:0] GP_IN_OFS = 8'h0C;
  localparam logic [7:0] DBG_STATUS_OFS = 8'h10;
  localparam logic [7:0] DBG_CMD_OFS = 8'h14;
  localparam logic [7:0] DBG_RESP_OFS = 8'h18;
  // Field positions.
  localparam int PAR_STATUS_BIT = 0;
  localparam int PAR_DATA_BIT = 1;
  localparam int ST_CMD_BIT = 0;
  localparam int ST_BREAKPOINT_REQUEST_N_BIT = 1;
  localparam int ST_MODE_BIT = 2;
  // Values after reset: pins are inputs, general purpose.
  localparam logic [1:0] PAR_RESET = 2'h0;
  localparam logic [7:0] GP_DIR_RESET = 8'h00;
  localparam logic [7:0] GP_OUT_RESET = 8'h00;
  // Processor status codes.
  localparam logic [3:0] PST_CONTINUE = 4'h0;
  localparam logic [3:0] PST_INSTR = 4'h1;
  localparam logic [3:0] PST_USER = 4'h3;
  localparam logic [3:0] PST_PULSE = 4'h4;
  localparam logic [3:0] PST_BRANCH = 4'h5;
  localparam logic [3:0] PST_RTE = 4'h7;
  localparam logic [3:0] PST_EXCEPT = 4'hC;
  localparam logic [3:0] PST_EMU = 4'hD;
  localparam logic [3:0] PST_STOPPED = 4'hE;
  localparam logic [3:0] PST_HALTED = 4'hF;
  // Debug data nibble shown while the core reports a breakpoint.
  localparam logic [3:0] DDATA_BREAKPOINT_REQUEST_N = 4'hF;
  // Cycles that a multi-cycle status code stands at least.
  localparam logic [1:0] PST_HOLD_CYCLES = 2'h2;
  // Bits in one serial debug frame.
  localparam int FRAME_BITS = 17;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  // Width of the input synchroniser vector.
  localparam int SYNC_W = 14;
endpackage

// [logic/dsp_serial_port.sv]
// Serial debug shifter working from synchronised clock and data levels.
`timescale 1ns/1ps
module dsp_serial_port (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Synchronised serial pins and mode.
  input wire logic enable,
  input wire logic sclk_s,
  input wire logic sdi_s,
  // Word to send and word received.
  input wire logic [dsp_pkg::FRAME_BITS-1:0] resp_word,
  output logic [dsp_pkg::FRAME_BITS-1:0] cmd_word_q,
  output logic cmd_valid_q,
  output logic sdo_q
);
  // Previous serial clock level for edge detection.
  logic sclk_prev_q;
  // Bit counter within a frame.
  logic [4:0] cnt_q;
  // Receive and transmit shift registers.
  logic [dsp_pkg::FRAME_BITS-1:0] rx_q;
  logic [dsp_pkg::FRAME_BITS-1:0] tx_q;

  // Edges need a serial clock at most half the system rate.
  wire sclk_rise = enable & sclk_s & ~sclk_prev_q;
  wire sclk_fall = enable & ~sclk_s & sclk_prev_q;
  wire frame_end = sclk_rise && (cnt_q == dsp_pkg::FRAME_LAST);
  wire [dsp_pkg::FRAME_BITS-1:0] rx_next = {rx_q[dsp_pkg::FRAME_BITS-2:0], sdi_s};

  ////////////////////////////////////////////////////////////////////////
  // Edge tracking and receive path; data is taken on the rising edge.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      cnt_q <= 5'h00;
      rx_q <= '0;
      cmd_word_q <= '0;
      cmd_valid_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      cmd_valid_q <= frame_end;
      if (!enable) begin
        // Leaving debug mode drops a partial frame.
        cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        rx_q <= rx_next;
        cnt_q <= frame_end ? 5'h00 : cnt_q + 5'h01;
      end
      if (frame_end) begin
        cmd_word_q <= rx_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit path: reload at frame end, shift out on each falling edge.
  // No timeout exists, so an idle serial clock keeps all state.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_q <= '0;
      sdo_q <= 1'b0;
    end else if (frame_end) begin
      tx_q <= resp_word;
    end else if (sclk_fall) begin
      sdo_q <= tx_q[dsp_pkg::FRAME_BITS-1];
      tx_q <= {tx_q[dsp_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  // A command pulse always closes a frame with a cleared counter.
  a_frame_close: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_valid_q |-> cnt_q == 5'h00) else $error("frame counter not cleared");
endmodule

// [logic/dsp_debug_pins.sv]
// Debug status pins, shared port pins, serial debug port and AHB-Lite registers.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Codes 0000 continue, 0001 instruction, 0011 user.
// - Codes 0100 marker, 0101 branch, 0111 exception return.
// - Codes 1100 to 1111 exception, emulator, stop, halt.
// - Codes 1100 to 1111 stand at least two cycles.
// - Reserved codes are never driven.
// - Status follows processor clock, not bus transfers.
// - Pin assignment selects debug or port pins.
// - Reset leaves shared pins as port inputs.
// - Port mode: software sets direction and level.
// - Debug nibble shows captured data and breakpoint.
// - Test mode picks debug or scan pin functions.
// - Serial clock times command and response bits.
// - Breakpoint input low requests processor breakpoint.
// - Commands arrive serially on serial input.
// - Responses leave serially on serial output.
// - Scan logic runs on its own test clock.
// - Scan state survives a stopped test clock.
module dsp_debug_pins (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Processor events.
  input wire logic core_instr_begin,
  input wire logic core_user_entry,
  input wire logic core_pulse_begin,
  input wire logic core_branch_taken,
  input wire logic core_rte_begin,
  input wire logic core_exception,
  input wire logic core_emu_entry,
  input wire logic core_stopped,
  input wire logic core_halted,
  input wire logic [3:0] core_debug_data,
  input wire logic core_breakpoint_request_n_status,
  output logic breakpoint_req,
  // Shared status and port pins.
  input wire logic [3:0] gp_port_upper_i,
  output logic [3:0] gp_port_upper_o,
  output logic [3:0] gp_port_upper_oe,
  input wire logic [3:0] gp_port_lower_i,
  output logic [3:0] gp_port_lower_o,
  output logic [3:0] gp_port_lower_oe,
  // Test and debug pins.
  input wire logic test_mode_select,
  input wire logic debug_serial_clock,
  input wire logic breakpoint_request_n,
  input wire logic debug_serial_in,
  output logic debug_serial_out,
  output logic debug_serial_out_oe,
  // Boundary-scan controller side.
  input wire logic scan_tdo,
  input wire logic scan_tdo_oe,
  output logic scan_tck,
  output logic scan_tms,
  output logic scan_tdi
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser; the first stage feeds only the second.
  logic [dsp_pkg::SYNC_W-1:0] sync1_q;
  logic [dsp_pkg::SYNC_W-1:0] sync2_q;
  wire [dsp_pkg::SYNC_W-1:0] async_in = {test_mode_select, debug_serial_clock,
    breakpoint_request_n, debug_serial_in, scan_tdo, scan_tdo_oe,
    gp_port_upper_i, gp_port_lower_i};

  // Two flops per pin before any logic reads it.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  // Synchronised levels; test mode is held steady by the host.
  wire dbg_mode = sync2_q[13];
  wire pin_clk_s = sync2_q[12];
  wire pin_breakpoint_request_n_s = sync2_q[11];
  wire pin_din_s = sync2_q[10];
  wire tdo_s = sync2_q[9];
  wire tdo_oe_s = sync2_q[8];
  wire [7:0] gp_in_s = sync2_q[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [1:0] par_q; // Pin assignment: bit 0 status pins, bit 1 data pins.
  logic [7:0] gp_dir_q; // Port direction, 1 drives.
  logic [7:0] gp_out_q; // Port output levels.
  logic [dsp_pkg::FRAME_BITS-1:0] resp_q; // Next serial response.
  logic cmd_flag_q; // Sticky: command received.
  logic breakpoint_request_n_flag_q; // Sticky: breakpoint taken.
  logic breakpoint_request_n_prev_q; // Previous breakpoint level.
  // Captured bus address phase.
  logic wr_q;
  logic [7:0] addr_q;
  // Status code machinery.
  logic [3:0] pst_q;
  logic [1:0] hold_q;
  // Serial port results.
  logic [dsp_pkg::FRAME_BITS-1:0] cmd_word;
  logic cmd_valid;
  logic sdo;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_go = wr_q & hready;
  wire wr_par = wr_go && addr_q == dsp_pkg::PIN_ASSIGN_OFS;
  wire wr_dir = wr_go && addr_q == dsp_pkg::GP_DIR_OFS;
  wire wr_out = wr_go && addr_q == dsp_pkg::GP_OUT_OFS;
  wire wr_stat = wr_go && addr_q == dsp_pkg::DBG_STATUS_OFS;
  wire wr_resp = wr_go && addr_q == dsp_pkg::DBG_RESP_OFS;
  wire [7:0] ra = haddr[7:0];
  wire [31:0] status_word = {25'h0, pst_q, dbg_mode, breakpoint_request_n_flag_q, cmd_flag_q};
  // Read data for the address now presented; unmapped reads as zero.
  wire [31:0] rd_mux =
    (ra == dsp_pkg::PIN_ASSIGN_OFS) ? {30'h0, par_q} :
    (ra == dsp_pkg::GP_DIR_OFS) ? {24'h0, gp_dir_q} :
    (ra == dsp_pkg::GP_OUT_OFS) ? {24'h0, gp_out_q} :
    (ra == dsp_pkg::GP_IN_OFS) ? {24'h0, gp_in_s} :
    (ra == dsp_pkg::DBG_STATUS_OFS) ? status_word :
    (ra == dsp_pkg::DBG_CMD_OFS) ? {15'h0, cmd_word} :
    (ra == dsp_pkg::DBG_RESP_OFS) ? {15'h0, resp_q} : 32'h0000_0000;

  // Bus slave: no wait states, always OKAY, read data registered.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_q <= addr_phase & hwrite;
        addr_q <= haddr[7:0];
      end
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Software-written registers; reset sets all shared pins to inputs.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      par_q <= dsp_pkg::PAR_RESET;
      gp_dir_q <= dsp_pkg::GP_DIR_RESET;
      gp_out_q <= dsp_pkg::GP_OUT_RESET;
      resp_q <= '0;
    end else begin
      if (wr_par) par_q <= hwdata[1:0];
      if (wr_dir) gp_dir_q <= hwdata[7:0];
      if (wr_out) gp_out_q <= hwdata[7:0];
      if (wr_resp) resp_q <= hwdata[dsp_pkg::FRAME_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status encoder: highest priority event wins, reserved codes never made.
  wire any_high = core_halted | core_stopped | core_emu_entry | core_exception;
  wire [3:0] pst_next =
    core_halted ? dsp_pkg::PST_HALTED :
    core_stopped ? dsp_pkg::PST_STOPPED :
    core_emu_entry ? dsp_pkg::PST_EMU :
    core_exception ? dsp_pkg::PST_EXCEPT :
    core_rte_begin ? dsp_pkg::PST_RTE :
    core_branch_taken ? dsp_pkg::PST_BRANCH :
    core_pulse_begin ? dsp_pkg::PST_PULSE :
    core_user_entry ? dsp_pkg::PST_USER :
    core_instr_begin ? dsp_pkg::PST_INSTR : dsp_pkg::PST_CONTINUE;
  wire hold_busy = hold_q != 2'h0;
  wire [3:0] pst_d = hold_busy ? pst_q : pst_next;
  wire multi = pst_next[3:2] == 2'b11;

  // Status runs every processor clock, blind to bus traffic.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pst_q <= dsp_pkg::PST_CONTINUE;
      hold_q <= 2'h0;
    end else begin
      pst_q <= pst_d;
      if (hold_busy) begin
        hold_q <= hold_q - 2'h1;
      end else begin
        hold_q <= multi ? dsp_pkg::PST_HOLD_CYCLES - 2'h1 : 2'h0;
      end
    end
  end

  // Debug nibble: breakpoint marker overrides captured data.
  wire [3:0] ddata_d = core_breakpoint_request_n_status ? dsp_pkg::DDATA_BREAKPOINT_REQUEST_N : core_debug_data;

  ////////////////////////////////////////////////////////////////////////
  // Shared pin drivers, registered; status from next-state pst_d, port levels from gp_out_q and gp_dir_q.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gp_port_upper_o <= 4'h0;
      gp_port_upper_oe <= 4'h0;
      gp_port_lower_o <= 4'h0;
      gp_port_lower_oe <= 4'h0;
    end else begin
      gp_port_upper_o <= par_q[dsp_pkg::PAR_STATUS_BIT] ? pst_d : gp_out_q[7:4];
      gp_port_upper_oe <= par_q[dsp_pkg::PAR_STATUS_BIT] ? 4'hF : gp_dir_q[7:4];
      gp_port_lower_o <= par_q[dsp_pkg::PAR_DATA_BIT] ? ddata_d : gp_out_q[3:0];
      gp_port_lower_oe <= par_q[dsp_pkg::PAR_DATA_BIT] ? 4'hF : gp_dir_q[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial debug port, active only in debug mode.
  dsp_serial_port dsp_serial_port_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(dbg_mode),
    .sclk_s(pin_clk_s),
    .sdi_s(pin_din_s),
    .resp_word(resp_q),
    .cmd_word_q(cmd_word),
    .cmd_valid_q(cmd_valid),
    .sdo_q(sdo)
  );

  // Breakpoint assertion edge, seen only in debug mode.
  wire breakpoint_request_n_fall = dbg_mode & breakpoint_request_n_prev_q & ~pin_breakpoint_request_n_s;

  // Breakpoint request and sticky flags; a set beats a same-cycle clear.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      breakpoint_request_n_prev_q <= 1'b1;
      breakpoint_req <= 1'b0;
      breakpoint_request_n_flag_q <= 1'b0;
      cmd_flag_q <= 1'b0;
    end else begin
      breakpoint_request_n_prev_q <= pin_breakpoint_request_n_s;
      breakpoint_req <= breakpoint_request_n_fall;
      breakpoint_request_n_flag_q <= breakpoint_request_n_fall | (breakpoint_request_n_flag_q & ~(wr_stat & hwdata[dsp_pkg::ST_BREAKPOINT_REQUEST_N_BIT]));
      cmd_flag_q <= cmd_valid | (cmd_flag_q & ~(wr_stat & hwdata[dsp_pkg::ST_CMD_BIT]));
    end
  end

  // Four dual pins: debug functions or pass-through to the scan controller,
  // which runs on the test clock alone and keeps its state when it stops.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scan_tck <= 1'b0;
      scan_tms <= 1'b1;
      scan_tdi <= 1'b1;
      debug_serial_out <= 1'b0;
      debug_serial_out_oe <= 1'b0;
    end else begin
      scan_tck <= dbg_mode ? 1'b0 : pin_clk_s;
      scan_tms <= dbg_mode ? 1'b1 : pin_breakpoint_request_n_s;
      scan_tdi <= dbg_mode ? 1'b1 : pin_din_s;
      debug_serial_out <= dbg_mode ? sdo : tdo_s;
      debug_serial_out_oe <= dbg_mode ? 1'b1 : tdo_oe_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // The first edge out of reset must still show every shared pin as an input.
  a_reset_pins_in: assert property ($past(reset) |->
    gp_port_upper_oe == 4'h0 && gp_port_lower_oe == 4'h0)
    else $error("shared pins driven after reset");
  a_pst_not_reserved: assert property (
    !(pst_q inside {4'h2, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB}))
    else $error("reserved status code");
  a_pst_multi_hold: assert property (
    $changed(pst_q) && pst_q[3:2] == 2'b11 |=> $stable(pst_q))
    else $error("multi-cycle code held one cycle");
  a_pst_halt_code: assert property (!hold_busy && core_halted |=> pst_q == 4'hF)
    else $error("halt code missing");
  a_pst_instr_code: assert property (!hold_busy && !any_high && core_instr_begin &&
    !core_rte_begin && !core_branch_taken && !core_pulse_begin && !core_user_entry
    |=> pst_q == 4'h1) else $error("instruction code missing");
  a_pst_branch_code: assert property (!hold_busy && !any_high && !core_rte_begin &&
    core_branch_taken |=> pst_q == 4'h5) else $error("branch code missing");
  a_status_pin_mux: assert property (par_q[0] && $stable(par_q) |=>
    gp_port_upper_oe == 4'hF && gp_port_upper_o == pst_q)
    else $error("status not on pins");
  a_gp_dir_drive: assert property (!par_q[1] && $stable(par_q) |=>
    gp_port_lower_oe == $past(gp_dir_q[3:0])) else $error("port direction ignored");
  a_breakpoint_request_n_pulse: assert property (breakpoint_request_n_fall |=> breakpoint_req ##1 !breakpoint_req)
    else $error("breakpoint request not one pulse");
  a_scan_route: assert property (!dbg_mode |=> debug_serial_out == $past(tdo_s))
    else $error("scan data not routed");

  c_halt_seen: cover property (pst_q == 4'hF ##1 pst_q == 4'hF);
  c_cmd_frame: cover property (cmd_valid && dbg_mode);
  c_breakpoint_request_n_taken: cover property (breakpoint_req);
  c_gp_output: cover property (gp_port_lower_oe != 4'h0 && !par_q[1]);
endmodule

// [sim/dsp_probe_model.sv]
// Debug probe model that drives the serial debug pins from the host side.
`timescale 1ns/1ps
module dsp_probe_model (
  // Pins toward the device.
  output logic debug_serial_clock,
  output logic debug_serial_in,
  output logic breakpoint_request_n,
  // Pin from the device.
  input wire logic debug_serial_out
);
  // Outside frames the clock stands low and the pulled-up lines sit high.
  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b1;
    breakpoint_request_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sends one frame MSB first and reads each reply bit well after the rise.
  task automatic send_frame(input logic [16:0] cmd, output logic [16:0] rsp);
    // Step off the system clock edge so no pin moves on a sampling edge.
    #30;
    for (int i = 16; i >= 0; i--) begin
      debug_serial_in <= cmd[i];
      #200;
      // An 800 ns period keeps the clock far below half the system rate.
      debug_serial_clock <= 1'b1;
      #300;
      rsp[i] = debug_serial_out;
      #100;
      debug_serial_clock <= 1'b0;
      #200;
    end
    debug_serial_in <= 1'b1;
  endtask

  // Sets the three pin levels directly, used for breakpoints and scan mode.
  task automatic set_pins(input logic c, input logic d, input logic b);
    debug_serial_clock <= c;
    debug_serial_in <= d;
    breakpoint_request_n <= b;
  endtask
endmodule

// [sim/tb_dsp_debug_pins.sv]
// Self-checking testbench for the debug status pin interface.
`timescale 1ns/1ps
module tb_dsp_debug_pins;
  // Bus, core and pin signals.
  logic sys_clk, reset, hsel, hwrite, hreadyout, hresp, breakpoint_request_n_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] ev;
  logic [3:0] core_dd, up_i, up_o, up_oe, lo_i, lo_o, lo_oe;
  logic breakpoint_request_n_st, tms_sel, dclk, din, bkn, dout, dout_oe, tdo, tdo_oe, tck, tms, tdi;
  logic [16:0] rsp;
  int err_total, n_checks;
  // Expected status code for each event bit.
  logic [3:0] code_tab [9];

  dsp_debug_pins dsp_debug_pins_inst (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .core_instr_begin(ev[0]), .core_user_entry(ev[1]), .core_pulse_begin(ev[2]),
    .core_branch_taken(ev[3]), .core_rte_begin(ev[4]), .core_exception(ev[5]),
    .core_emu_entry(ev[6]), .core_stopped(ev[7]), .core_halted(ev[8]),
    .core_debug_data(core_dd), .core_breakpoint_request_n_status(breakpoint_request_n_st), .breakpoint_req(breakpoint_request_n_req),
    .gp_port_upper_i(up_i), .gp_port_upper_o(up_o), .gp_port_upper_oe(up_oe),
    .gp_port_lower_i(lo_i), .gp_port_lower_o(lo_o), .gp_port_lower_oe(lo_oe),
    .test_mode_select(tms_sel), .debug_serial_clock(dclk), .breakpoint_request_n(bkn),
    .debug_serial_in(din), .debug_serial_out(dout), .debug_serial_out_oe(dout_oe),
    .scan_tdo(tdo), .scan_tdo_oe(tdo_oe), .scan_tck(tck), .scan_tms(tms), .scan_tdi(tdi));
  dsp_probe_model dsp_probe_model_inst (.debug_serial_clock(dclk), .debug_serial_in(din),
    .breakpoint_request_n(bkn), .debug_serial_out(dout));

  // The clock toggles every half period of 50 ns.
  always #50 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One AHB-Lite transfer; the address phase holds until hready is seen.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset state and port mode with direction, levels, inputs and a hole.
  task automatic t_port();
    chk("oe_reset", {up_oe, lo_oe}, 32'h0);
    bus(1'b0, dsp_pkg::PIN_ASSIGN_OFS, 32'h0);
    chk("par_reset", rd, 32'h0);
    bus(1'b0, dsp_pkg::GP_DIR_OFS, 32'h0);
    chk("dir_reset", rd, 32'h0);
    bus(1'b1, dsp_pkg::GP_DIR_OFS, 32'h0000_00F0);
    bus(1'b1, dsp_pkg::GP_OUT_OFS, 32'h0000_00A5);
    bus(1'b0, dsp_pkg::GP_IN_OFS, 32'h0);
    chk("gp_in", rd[7:0], 32'h93);
    chk("gp_oe", {up_oe, lo_oe}, 32'hF0);
    chk("gp_out", up_o, 32'hA);
    chk("gp_out_lo", lo_o, 32'h5);
    bus(1'b0, 8'h3C, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", hresp, 32'h0);
    // Lower pins to debug use, upper pins stay with the port.
    bus(1'b1, dsp_pkg::PIN_ASSIGN_OFS, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("par_split", {up_o, lo_o, up_oe, lo_oe}, 32'hA0FF);
    $display("test port done");
  endtask

  // Every status code, and the hold of the multi-cycle codes.
  task automatic t_status();
    bus(1'b1, dsp_pkg::PIN_ASSIGN_OFS, 32'h3);
    for (int i = 0; i < 9; i++) begin
      ev <= 9'h001 << i;
      @(posedge sys_clk);
      ev <= 9'h000;
      #1 chk("code", up_o, code_tab[i]);
      @(posedge sys_clk);
      #1 chk("hold", up_o, (i > 4) ? code_tab[i] : dsp_pkg::PST_CONTINUE);
      repeat (4) @(posedge sys_clk);
    end
    chk("dbg_oe", {up_oe, lo_oe}, 32'hFF);
    core_dd <= 4'h6;
    repeat (3) @(posedge sys_clk);
    chk("nibble", lo_o, 32'h6);
    breakpoint_request_n_st <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("nibble_breakpoint_request_n", lo_o, dsp_pkg::DDATA_BREAKPOINT_REQUEST_N);
    $display("test status done");
  endtask

  // Two frames back to back, then a breakpoint from the pin.
  task automatic t_serial();
    int cnt;
    bus(1'b1, dsp_pkg::DBG_RESP_OFS, 32'h0001_5A3C);
    dsp_probe_model_inst.send_frame(17'h1_2345, rsp);
    dsp_probe_model_inst.send_frame(17'h0_ABCD, rsp);
    chk("resp", rsp, 32'h0001_5A3C);
    chk("dso_oe", dout_oe, 32'h1);
    repeat (10) @(posedge sys_clk);
    bus(1'b0, dsp_pkg::DBG_CMD_OFS, 32'h0);
    chk("cmd", rd, 32'h0000_ABCD);
    bus(1'b0, dsp_pkg::DBG_STATUS_OFS, 32'h0);
    chk("st_cmd", rd[2:0], 32'h5);
    bus(1'b1, dsp_pkg::DBG_STATUS_OFS, 32'h1);
    bus(1'b0, dsp_pkg::DBG_STATUS_OFS, 32'h0);
    chk("st_clear", rd[1:0], 32'h0);
    cnt = 0;
    dsp_probe_model_inst.set_pins(1'b0, 1'b1, 1'b0);
    // Look just after each edge, once the registered pulse has settled.
    repeat (20) begin
      @(posedge sys_clk);
      #1 cnt += (breakpoint_request_n_req === 1'b1);
    end
    dsp_probe_model_inst.set_pins(1'b0, 1'b1, 1'b1);
    chk("breakpoint_request_n_pulse", cnt, 32'h1);
    bus(1'b0, dsp_pkg::DBG_STATUS_OFS, 32'h0);
    chk("st_breakpoint_request_n", rd[1], 32'h1);
    $display("test serial done");
  endtask

  // Scan mode, entered only while reset is held, and a stopped test clock.
  task automatic t_scan();
    reset <= 1'b1;
    tms_sel <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    tdo <= 1'b1;
    tdo_oe <= 1'b1;
    dsp_probe_model_inst.set_pins(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge sys_clk);
    chk("scan_pins", {tck, tms, tdi, dout, dout_oe}, 32'h13);
    chk("oe_reset2", {up_oe, lo_oe}, 32'h0);
    repeat (60) @(posedge sys_clk);
    chk("tck_held", tck, 32'h1);
    tdo <= 1'b0;
    dsp_probe_model_inst.set_pins(1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge sys_clk);
    chk("scan_pins2", {tck, tms, tdi, dout}, 32'h6);
    $display("test scan done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for four cycles, then each test in turn.
  initial begin
    code_tab = '{dsp_pkg::PST_INSTR, dsp_pkg::PST_USER, dsp_pkg::PST_PULSE,
      dsp_pkg::PST_BRANCH, dsp_pkg::PST_RTE, dsp_pkg::PST_EXCEPT, dsp_pkg::PST_EMU,
      dsp_pkg::PST_STOPPED, dsp_pkg::PST_HALTED};
    {sys_clk, hsel, hwrite, breakpoint_request_n_st, tdo, tdo_oe} = 6'h00;
    reset = 1'b1;
    tms_sel = 1'b1;
    {haddr, hwdata} = 64'h0;
    {htrans, hsize, ev} = {2'h0, 3'h2, 9'h000};
    {core_dd, up_i, lo_i} = 12'h093;
    err_total = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_port();
    t_status();
    t_serial();
    t_scan();
    close_out();
  end

  // Watchdog well beyond the roughly 50 us that the tests need.
  initial begin
    #2000000;
    err_total++;
    close_out();
  end
endmodule
